// ==== hw/rtc_stamp_output_control.sv ====
// Time-stamp capture, calendar/control registers and output pin routing.
`timescale 1ns/1ps
module rtc_stamp_output_control
    import rtc_stamp_pkg::*;
#(
    parameter int ADIV_W = 7,
    parameter int SDIV_W = 15
) (
    input wire logic i_clk,                  // RTC source clock
    input wire logic i_rst_b,                // System reset, active low
    input wire logic i_bkp_rst_b,            // Backup-domain reset, active low
    input wire logic i_async_tick,           // Asynchronous prescaler tick
    input wire logic i_second_tick,          // One-second tick of the calendar
    input wire logic [ADIV_W-1:0] i_async_div, // Async divider factor
    input wire logic [SDIV_W-1:0] i_sync_div,  // Sync divider factor
    input wire logic [15:0] i_sub_second,    // Live sub-second count
    input wire logic i_alarm_match,          // Alarm match event pulse
    input wire logic i_stamp_pin,            // Time-stamp input pin
    input wire logic [7:0] i_addr,           // Register byte address
    input wire logic [31:0] i_wdata,         // Write data
    input wire logic i_wr,                   // Write strobe
    input wire logic i_rd,                   // Read strobe
    output logic [31:0] o_rdata,             // Read data, one cycle later
    output pin_out_t o_primary_pin,          // Primary output pin
    output pin_out_t o_secondary_pin,        // Secondary output pin
    output logic o_alarm_pullup,             // Internal pull-up on alarm pin
    output logic o_alarm_irq,                // Alarm interrupt request
    output logic o_stamp_irq                 // Time-stamp interrupt request
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] time_q, date_q, ctrl_q, stat_q;
    logic [31:0] shadow_time_q, shadow_date_q;
    logic [31:0] st_time_q, st_date_q, st_sub_q;
    logic [SYNC_STAGES-1:0] pin_sync_q;
    logic pin_prev_q;
    logic [2:0] pin_arm_q;
    logic [1:0] stamp_pend_q;
    logic [31:0] pend_time_q, pend_date_q, pend_sub_q;
    logic stamp_set, ovr_set, alarm_set;
    logic init_ok;
    logic edge_hit;
    logic wr_time, wr_date, wr_ctrl, wr_stat;
    logic bkp_seen_q;

    assign init_ok = stat_q[ST_INIT_RDY];
    assign wr_time = i_wr && i_addr == OFS_TIME && init_ok;
    assign wr_date = i_wr && i_addr == OFS_DATE && init_ok;
    assign wr_ctrl = i_wr && i_addr == OFS_CTRL;
    assign wr_stat = i_wr && i_addr == OFS_STAT;

    // ------------------------------------------------------------------
    // Stamp pin synchronizer and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_sync_q <= '0;
            pin_prev_q <= 1'b0;
            pin_arm_q <= 3'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], i_stamp_pin};
            pin_prev_q <= pin_sync_q[1];
            pin_arm_q <= {pin_arm_q[1:0], 1'b1};
        end
    end

    // Only the second stage feeds the edge detector. The pin's idle level is
    // unknown at reset, so edges count only once the history holds samples.
    assign edge_hit = pin_arm_q[2] && ctrl_q[CTL_STAMP_EN] && (ctrl_q[CTL_EDGE] ?
        (pin_prev_q && !pin_sync_q[1]) :
        (!pin_prev_q && pin_sync_q[1]));

    // The event is held for two prescaler ticks before the flag rises, and
    // the calendar is taken at the event so the stamp reflects pin time.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stamp_pend_q <= 2'h0;
            pend_time_q <= 32'h0000_0000;
            pend_date_q <= 32'h0000_0000;
            pend_sub_q <= 32'h0000_0000;
        end else if (edge_hit && stamp_pend_q == 2'h0) begin
            stamp_pend_q <= 2'h2;
            pend_time_q <= time_q;
            pend_date_q <= date_q;
            pend_sub_q <= {16'h0000, i_sub_second};
        end else if (stamp_pend_q != 2'h0 && i_async_tick) begin
            stamp_pend_q <= stamp_pend_q - 2'h1;
        end
    end

    assign stamp_set = stamp_pend_q == 2'h1 && i_async_tick;
    assign ovr_set = stamp_set && stat_q[ST_STAMP];
    assign alarm_set = i_alarm_match;

    // ------------------------------------------------------------------
    // Calendar time and date
    // ------------------------------------------------------------------
    function automatic logic [5:0] hr_bin(input logic [31:0] t);
        hr_bin = 6'(t[21:20] * 10 + t[19:16]);
    endfunction : hr_bin

    function automatic logic [31:0] hr_set(input logic [31:0] t,
                                          input logic [5:0] h);
        logic [5:0] tens;
        tens = 6'(h / 10);
        hr_set = {t[31:22], tens[1:0], 4'(h - tens * 10), t[15:0]};
    endfunction : hr_set

    // Wrap is within the day; date carry belongs to the calendar counter.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bkp_seen_q <= 1'b0;
        end else begin
            bkp_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_bkp_rst_b) begin
        if (!i_bkp_rst_b) begin
            time_q <= RST_TIME;
            date_q <= RST_DATE;
        end else if (!bkp_seen_q && !ctrl_q[CTL_BYPASS]) begin
            time_q <= RST_TIME;
            date_q <= RST_DATE;
        end else begin
            if (wr_time) begin
                time_q <= i_wdata & MASK_TIME;
            end else if (i_second_tick && ctrl_q[CTL_ADD_H]) begin
                time_q <= hr_set(time_q, 6'((hr_bin(time_q) + 1) % 24));
            end else if (i_second_tick && ctrl_q[CTL_SUB_H]) begin
                time_q <= hr_set(time_q, 6'((hr_bin(time_q) + 23) % 24));
            end
            if (wr_date) begin
                date_q <= i_wdata & MASK_DATE;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shadow_time_q <= RST_TIME;
            shadow_date_q <= RST_DATE;
        end else if (i_async_tick) begin
            shadow_time_q <= time_q;
            shadow_date_q <= date_q;
        end
    end

    // ------------------------------------------------------------------
    // Control register: backup domain only
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_bkp_rst_b) begin
        if (!i_bkp_rst_b) begin
            ctrl_q <= RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= (i_wdata & MASK_CTRL) | 32'({
                init_ok ? i_wdata[CTL_HFMT] : ctrl_q[CTL_HFMT]}) << CTL_HFMT;
        end else if (i_second_tick) begin
            ctrl_q[CTL_ADD_H] <= 1'b0;
            ctrl_q[CTL_SUB_H] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_bkp_rst_b) begin
        if (!i_bkp_rst_b) begin
            stat_q <= RST_STAT;
        end else begin
            if (wr_stat) begin
                stat_q[ST_INIT_REQ] <= i_wdata[ST_INIT_REQ];
                stat_q[ST_INIT_RDY] <= i_wdata[ST_INIT_REQ];
            end
            // Set wins over a software clear in the same cycle.
            stat_q[ST_STAMP] <= stamp_set ||
                (stat_q[ST_STAMP] && !(wr_stat && !i_wdata[ST_STAMP]));
            stat_q[ST_OVR] <= ovr_set ||
                (stat_q[ST_OVR] && !(wr_stat && !i_wdata[ST_OVR]));
            stat_q[ST_ALARM] <= alarm_set ||
                (stat_q[ST_ALARM] && !(wr_stat && !i_wdata[ST_ALARM]));
            stat_q[ST_SYNCED] <= (i_async_tick && !ctrl_q[CTL_BYPASS] &&
                !stat_q[ST_INIT_REQ]) || (stat_q[ST_SYNCED] &&
                !(wr_stat && !i_wdata[ST_SYNCED]) && !ctrl_q[CTL_BYPASS]);
            // System reset clears only the init and sync bits; event flags
            // keep their history and may still be set in that cycle.
            if (!bkp_seen_q) begin
                stat_q[ST_INIT_REQ] <= 1'b0;
                stat_q[ST_INIT_RDY] <= 1'b0;
                stat_q[ST_SYNCED] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Time-stamp registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_bkp_rst_b) begin
        if (!i_bkp_rst_b) begin
            st_time_q <= 32'h0000_0000;
            st_date_q <= 32'h0000_0000;
            st_sub_q <= 32'h0000_0000;
        end else if (stamp_set && !stat_q[ST_STAMP]) begin
            st_time_q <= pend_time_q;
            st_date_q <= pend_date_q & 32'h0000_FF3F;
            st_sub_q <= pend_sub_q;
        end else if (wr_stat && !i_wdata[ST_STAMP] && stat_q[ST_STAMP]) begin
            st_time_q <= 32'h0000_0000;
            st_date_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Calibration clock
    // ------------------------------------------------------------------
    logic [5:0] cal_cnt_q;
    logic cal_fast_q, cal_slow_q;
    logic [SDIV_W:0] sec_cnt_q;
    logic cal_clk;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cal_cnt_q <= 6'h00;
            cal_fast_q <= 1'b0;
        end else begin
            if (cal_cnt_q == 6'(CAL_FIXED_DIV / 2 - 1)) begin
                cal_cnt_q <= 6'h00;
                cal_fast_q <= ~cal_fast_q;
            end else begin
                cal_cnt_q <= cal_cnt_q + 6'h01;
            end
        end
    end

    // Counts async ticks over sync_divider+1 to a one-second square wave.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sec_cnt_q <= '0;
            cal_slow_q <= 1'b0;
        end else if (i_async_tick) begin
            if (sec_cnt_q >= {1'b0, i_sync_div}) begin
                sec_cnt_q <= '0;
            end else begin
                sec_cnt_q <= sec_cnt_q + 1'b1;
            end
            cal_slow_q <= sec_cnt_q < (SDIV_W + 1)'((i_sync_div + 1) >> 1);
        end
    end

    assign cal_clk = ctrl_q[CTL_CAL_SEL] ? cal_slow_q : cal_fast_q;

    // ------------------------------------------------------------------
    // Alarm output and pin routing
    // ------------------------------------------------------------------
    logic alarm_on, cal_on, alarm_lvl;
    pin_out_t alarm_pin, cal_pin;

    assign alarm_on = ctrl_q[CTL_OSEL_LO +: 2] != OSEL_OFF;
    assign cal_on = ctrl_q[CTL_CAL_EN];
    assign alarm_lvl = (ctrl_q[CTL_OSEL_LO +: 2] == OSEL_ALARM) &&
        (stat_q[ST_ALARM] ^ ctrl_q[CTL_INVERT]);
    // Open drain drives only the low level; high is released.
    assign alarm_pin.drive = ctrl_q[CTL_DRIVE_OD] ? 1'b0 : alarm_lvl;
    assign alarm_pin.oe = ctrl_q[CTL_DRIVE_OD] ? !alarm_lvl : 1'b1;
    assign o_alarm_pullup = alarm_on && ctrl_q[CTL_DRIVE_OD] &&
        !ctrl_q[CTL_PU_DIS];
    assign cal_pin.drive = cal_clk;
    assign cal_pin.oe = 1'b1;

    always_comb begin
        o_primary_pin = '0;
        o_secondary_pin = '0;
        if (!ctrl_q[CTL_OUT2_EN]) begin
            if (alarm_on) begin
                o_primary_pin = alarm_pin;
            end else if (cal_on) begin
                o_primary_pin = cal_pin;
            end
        end else if (alarm_on && cal_on) begin
            o_primary_pin = alarm_pin;
            o_secondary_pin = cal_pin;
        end else if (alarm_on) begin
            o_secondary_pin = alarm_pin;
        end else if (cal_on) begin
            o_secondary_pin = cal_pin;
        end
    end

    assign o_alarm_irq = stat_q[ST_ALARM] && ctrl_q[CTL_ALM_IE];
    assign o_stamp_irq = stat_q[ST_STAMP] && ctrl_q[CTL_STAMP_IE];

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                OFS_TIME: o_rdata <= ctrl_q[CTL_BYPASS] ? time_q :
                    shadow_time_q;
                OFS_DATE: o_rdata <= ctrl_q[CTL_BYPASS] ? date_q :
                    shadow_date_q;
                OFS_CTRL: o_rdata <= ctrl_q;
                OFS_STAT: o_rdata <= stat_q;
                OFS_STAMP_TIME: o_rdata <= st_time_q;
                OFS_STAMP_DATE: o_rdata <= st_date_q;
                OFS_STAMP_SUB: o_rdata <= st_sub_q;
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_IRQ_ALARM: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        i_alarm_match && ctrl_q[CTL_ALM_IE] && !wr_ctrl |=> o_alarm_irq)
        else $error("alarm irq missing");
    AST_STAMP_FREEZE: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        stat_q[ST_STAMP] && !wr_stat |=> $stable(st_time_q))
        else $error("stamp changed while flag set");
    AST_OVR: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        ovr_set |=> stat_q[ST_OVR])
        else $error("overrun not raised");
    AST_WRITE_PROT: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        i_wr && i_addr == OFS_TIME && !init_ok && !i_second_tick
        |=> $stable(time_q))
        else $error("time written outside init");
    AST_CAL_OFF: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        !alarm_on && !cal_on |-> !o_primary_pin.oe && !o_secondary_pin.oe)
        else $error("pin driven with no source");
    AST_STAMP_SET: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        stamp_set |=> stat_q[ST_STAMP])
        else $error("stamp flag not set");
    AST_ALARM_INV: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        ctrl_q[CTL_OSEL_LO +: 2] == OSEL_ALARM && !ctrl_q[CTL_DRIVE_OD] &&
        !ctrl_q[CTL_OUT2_EN] |-> o_primary_pin.oe &&
        o_primary_pin.drive == (stat_q[ST_ALARM] ^ ctrl_q[CTL_INVERT]))
        else $error("alarm polarity wrong");
    AST_IRQ_STAMP: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        $rose(stat_q[ST_STAMP]) && ctrl_q[CTL_STAMP_IE] |-> o_stamp_irq)
        else $error("stamp irq missing");
    AST_STAMP_CLEAR: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        wr_stat && !i_wdata[ST_STAMP] && stat_q[ST_STAMP] && !stamp_set
        |=> st_time_q == 32'h0000_0000 && st_date_q == 32'h0000_0000)
        else $error("stamp not cleared");

endmodule : rtc_stamp_output_control

// ==== hw/rtc_stamp_pkg.sv ====
// Package of register map, field positions and reset values for the RTC block.
package rtc_stamp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TIME = 8'h00;
    localparam logic [7:0] OFS_DATE = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_STAMP_TIME = 8'h30;
    localparam logic [7:0] OFS_STAMP_DATE = 8'h34;
    localparam logic [7:0] OFS_STAMP_SUB = 8'h38;

    // ------------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_TIME = 32'h0000_0000;
    localparam logic [31:0] RST_DATE = 32'h0000_2101;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_STAT = 32'h0000_0007;
    localparam logic [31:0] MASK_TIME = 32'h007F_7F7F;
    localparam logic [31:0] MASK_DATE = 32'h00FF_FF3F;
    localparam logic [31:0] MASK_CTRL = 32'h80FF_983F;

    // ------------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------------
    localparam int CTL_EDGE = 3;
    localparam int CTL_REF = 4;
    localparam int CTL_BYPASS = 5;
    localparam int CTL_HFMT = 6;
    localparam int CTL_ALM_IE = 12;
    localparam int CTL_STAMP_IE = 15;
    localparam int CTL_ADD_H = 16;
    localparam int CTL_SUB_H = 17;
    localparam int CTL_CAL_SEL = 19;
    localparam int CTL_INVERT = 20;
    localparam int CTL_OSEL_LO = 21;
    localparam int CTL_CAL_EN = 23;
    localparam int CTL_OUT2_EN = 31;
    localparam int CTL_STAMP_EN = 11;
    localparam int CTL_DRIVE_OD = 1;
    localparam int CTL_PU_DIS = 2;

    // ------------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------------
    localparam int ST_INIT_REQ = 7;
    localparam int ST_INIT_RDY = 6;
    localparam int ST_SYNCED = 5;
    localparam int ST_STAMP = 11;
    localparam int ST_OVR = 12;
    localparam int ST_ALARM = 8;
    localparam logic [31:0] MASK_STAT_SW0 = 32'h0000_1920;

    localparam logic [1:0] OSEL_OFF = 2'h0;
    localparam logic [1:0] OSEL_ALARM = 2'h1;
    localparam int CAL_FIXED_DIV = 64;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic drive;
        logic oe;
    } pin_out_t;

endpackage : rtc_stamp_pkg

// ==== tb/board_model.sv ====
// Board model for the primary output wire and the shared stamp pin.
`timescale 1ns/1ps
module board_model
    import rtc_stamp_pkg::*;
(
    input wire logic i_clk, // Clock for wire history
    input wire pin_out_t i_primary, // Primary pin from block
    input wire logic i_pullup, // Internal pull-up enable
    input wire logic i_level, // Level the board applies
    output logic o_stamp_pin, // Stamp pin into block
    output logic o_primary_level // Resolved primary wire
);
    logic last_q;
    assign o_stamp_pin = i_level;
    // An undriven wire without pull-up flips, so stale values never match.
    always_comb begin
        if (i_primary.oe) o_primary_level = i_primary.drive;
        else if (i_pullup) o_primary_level = 1'b1;
        else o_primary_level = ~last_q;
    end
    always_ff @(posedge i_clk) last_q <= o_primary_level;
endmodule : board_model

// ==== tb/testbench.sv ====
// Self-checking bench for the RTC stamp and output block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
    import rtc_stamp_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, bkp_b = 1'b0, tick = 1'b0;
    logic alm = 1'b0, wr = 1'b0, rd = 1'b0, lvl = 1'b0, sec = 1'b0, pin, p_lvl;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rdata;
    pin_out_t p1, p2;
    logic pu, a_irq, s_irq;
    int miscompares = 0, checked = 0;
    always #12.5 clk = ~clk;
    rtc_stamp_output_control uut (.i_clk(clk), .i_rst_b(rst_b),
        .i_bkp_rst_b(bkp_b), .i_async_tick(tick), .i_second_tick(sec),
        .i_async_div(7'h7F), .i_sync_div(15'h00FF),
        .i_sub_second(16'h1234), .i_alarm_match(alm), .i_stamp_pin(pin),
        .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_primary_pin(p1), .o_secondary_pin(p2), .o_alarm_pullup(pu),
        .o_alarm_irq(a_irq), .o_stamp_irq(s_irq));
    board_model brd (.i_clk(clk), .i_primary(p1), .i_pullup(pu),
        .i_level(lvl), .o_stamp_pin(pin), .o_primary_level(p_lvl));
    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    task automatic rd32(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rdat = rdata;
    endtask : rd32
    task automatic pulse_tick;
        @(posedge clk) tick <= 1'b1;
        @(posedge clk) tick <= 1'b0;
    endtask : pulse_tick
    task automatic stamp_event(input logic edge_sel);
        @(posedge clk) lvl <= edge_sel;
        repeat (4) @(posedge clk);
        @(posedge clk) lvl <= ~edge_sel;
        repeat (4) @(posedge clk);
        pulse_tick();
        pulse_tick();
        repeat (2) @(posedge clk);
    endtask : stamp_event
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd32(OFS_TIME); `CHK("time", 32'h0, rdat)
        rd32(OFS_DATE); `CHK("date", 32'h0000_2101, rdat)
        rd32(OFS_CTRL); `CHK("ctrl", 32'h0, rdat)
        rd32(OFS_STAT); `CHK("stat", 32'h0000_0007, rdat)
        rd32(8'h20); `CHK("unmapped", 32'h0, rdat)
        `CHK("pin1", 2'h0, p1)
    endtask : t_reset
    task automatic t_protect;
        wr32(OFS_TIME, 32'h0012_3456);
        pulse_tick();
        rd32(OFS_TIME); `CHK("time lock", 32'h0, rdat)
        wr32(OFS_STAT, 32'h0000_0080);
        rd32(OFS_STAT); `CHK("init rdy", 1'b1, rdat[6])
        wr32(OFS_CTRL, 32'h0000_0010);
        rd32(OFS_CTRL); `CHK("ref en", 1'b1, rdat[4])
        wr32(OFS_TIME, 32'h0023_5959);
        wr32(OFS_DATE, 32'h0024_E531);
        rd32(OFS_TIME); `CHK("shadow", 32'h0, rdat)
        pulse_tick();
        rd32(OFS_TIME); `CHK("time", 32'h0023_5959, rdat)
        rd32(OFS_DATE); `CHK("date", 32'h0024_E531, rdat)
        wr32(OFS_STAT, 32'h0000_0000);
        wr32(OFS_TIME, 32'h0001_0101);
        wr32(OFS_CTRL, 32'h0000_0040);
        pulse_tick();
        rd32(OFS_TIME); `CHK("time lock", 32'h0023_5959, rdat)
        rd32(OFS_CTRL); `CHK("fmt lock", 32'h0, rdat)
    endtask : t_protect
    task automatic t_stamp(input logic edge_sel);
        @(posedge clk) lvl <= edge_sel;
        wr32(OFS_CTRL, 32'h0000_8800 | (32'(edge_sel) << 3));
        repeat (4) @(posedge clk);
        @(posedge clk) lvl <= ~edge_sel;
        repeat (4) @(posedge clk);
        pulse_tick();
        repeat (2) @(posedge clk);
        `CHK("irq early", 1'b0, s_irq)
        pulse_tick();
        repeat (2) @(posedge clk);
        `CHK("stamp irq", 1'b1, s_irq)
        rd32(OFS_STAMP_TIME); `CHK("st time", 32'h0023_5959, rdat)
        rd32(OFS_STAMP_DATE); `CHK("st date", 32'h0000_E531, rdat)
        rd32(OFS_STAMP_SUB); `CHK("st sub", 32'h0000_1234, rdat)
        stamp_event(edge_sel);
        rd32(OFS_STAT); `CHK("overrun", 2'h3, rdat[12:11])
        rd32(OFS_STAMP_TIME); `CHK("st hold", 32'h0023_5959, rdat)
        wr32(OFS_STAT, 32'h0000_0000);
        rd32(OFS_STAMP_TIME); `CHK("st clear", 32'h0, rdat)
        rd32(OFS_STAT); `CHK("flags", 2'h0, rdat[12:11])
        `CHK("irq off", 1'b0, s_irq)
    endtask : t_stamp
    task automatic t_alarm;
        wr32(OFS_CTRL, 32'h0020_1000);
        @(posedge clk) alm <= 1'b1;
        @(posedge clk) alm <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("alm pin", 2'h3, p1)
        `CHK("alm irq", 1'b1, a_irq)
        wr32(OFS_CTRL, 32'h0030_0000);
        #1 `CHK("alm inv", 2'h1, p1)
        wr32(OFS_CTRL, 32'h8020_0000);
        #1 `CHK("alm pin2", 2'h3, p2)
        `CHK("pin1 off", 1'b0, p1.oe)
        wr32(OFS_CTRL, 32'h80A0_0000);
        #1 `CHK("both p1", 2'h3, p1)
        `CHK("both p2", 1'b1, p2.oe)
        wr32(OFS_CTRL, 32'h0020_0002);
        #1 `CHK("pullup", 1'b1, pu)
        `CHK("od level", 1'b1, p_lvl)
        wr32(OFS_CTRL, 32'h0020_0006);
        #1 `CHK("pullup off", 1'b0, pu)
        wr32(OFS_CTRL, 32'h0000_1000);
        #1 `CHK("off", 1'b0, p1.oe)
        `CHK("alm kept", 1'b1, a_irq)
        wr32(OFS_STAT, 32'h0000_0000);
        #1 `CHK("alm clr", 1'b0, a_irq)
    endtask : t_alarm
    task automatic t_cal(input logic sel);
        int n;
        int k;
        wr32(OFS_CTRL, 32'h0080_0000 | (32'(sel) << 19));
        for (k = 0; k < 2; k++) begin
            n = 0;
            while (!(p_lvl === 1'b0 && n > 0) && n < 900) begin
                if (sel) pulse_tick();
                else @(posedge clk);
                n++;
            end
            n = 0;
            while (p_lvl !== 1'b1 && n < 900) begin
                if (sel) pulse_tick();
                else @(posedge clk);
                n++;
            end
            if (n >= 900) begin
                miscompares++;
                test_done();
            end
        end
        n = 0;
        while ((p_lvl === 1'b1 || n < 2) && n < 900) begin
            if (sel) pulse_tick();
            else @(posedge clk);
            n++;
        end
        while (p_lvl !== 1'b1 && n < 900) begin
            if (sel) pulse_tick();
            else @(posedge clk);
            n++;
        end
        `CHK("cal period", sel ? 256 : 64, n)
    endtask : t_cal
    task automatic t_hour;
        wr32(OFS_CTRL, 32'h0001_0000);
        @(posedge clk) sec <= 1'b1;
        @(posedge clk) sec <= 1'b0;
        pulse_tick();
        rd32(OFS_TIME); `CHK("add hour", 32'h0000_5959, rdat)
        rd32(OFS_CTRL); `CHK("add done", 32'h0, rdat)
        wr32(OFS_CTRL, 32'h0002_0000);
        @(posedge clk) sec <= 1'b1;
        @(posedge clk) sec <= 1'b0;
        pulse_tick();
        rd32(OFS_TIME); `CHK("sub hour", 32'h0023_5959, rdat)
    endtask : t_hour
    task automatic t_sysrst;
        wr32(OFS_CTRL, 32'h0000_8800);
        wr32(OFS_STAT, 32'h0000_0080);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rd32(OFS_CTRL); `CHK("ctrl kept", 32'h0000_8800, rdat)
        rd32(OFS_STAT); `CHK("init bits", 3'h0, rdat[7:5])
        pulse_tick();
        rd32(OFS_TIME); `CHK("time rst", 32'h0, rdat)
        rd32(OFS_DATE); `CHK("date rst", 32'h0000_2101, rdat)
    endtask : t_sysrst
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        bkp_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_protect();
        t_stamp(1'b0);
        t_stamp(1'b1);
        t_alarm();
        t_cal(1'b0);
        t_cal(1'b1);
        t_hour();
        t_sysrst();
        test_done();
    end
endmodule : testbench
